// file: pkg/sdr_pkg.sv
/*
  Package for the loop-two divider, readback and lock register bank.
  Holds register numbers, field positions, reset values and the state type.
  Assumes a serial word of 32 bits with the register number in its low 5 bits.
*/
package sdr_pkg;
  localparam int          SDR_WORD_W        = 32;
  localparam int          SDR_ADDR_W        = 5;
  localparam int          SDR_DIV_W         = 18;
  // register numbers, equal to the readback codes
  localparam logic [4:0]  SDR_REG_CAL_DIV   = 5'h1d;
  localparam logic [4:0]  SDR_REG_FB_DIV    = 5'h1e;
  localparam logic [4:0]  SDR_REG_RB_LOCK   = 5'h1f;
  localparam logic [4:0]  SDR_REG_STATUS12  = 5'h0c;
  localparam logic [4:0]  SDR_REG_RSV9      = 5'h09;
  localparam logic [4:0]  SDR_RSV_LO        = 5'h10;
  localparam logic [4:0]  SDR_RSV_HI        = 5'h17;
  // field positions
  localparam int          SDR_ADDR_LSB      = 0;
  localparam int          SDR_REF_RANGE_LSB = 24;
  localparam int          SDR_FAST_BIT      = 23;
  localparam int          SDR_DIV_LSB       = 5;
  localparam int          SDR_PRESC_LSB     = 24;
  localparam int          SDR_RB_POL_BIT    = 21;
  localparam int          SDR_RB_ADDR_LSB   = 16;
  localparam int          SDR_LOCK_BIT      = 5;
  // prescaler decoding
  localparam logic [3:0]  SDR_PRESC_ZERO    = 4'h8;
  localparam logic [2:0]  SDR_PRESC_MIN     = 3'h3;
  localparam logic [3:0]  SDR_PRESC_LOW     = 4'h2;
  // reset values
  localparam logic [2:0]  SDR_RST_3         = 3'h0;
  localparam logic [4:0]  SDR_RST_ADDR      = 5'h00;
  localparam logic [17:0] SDR_RST_DIV       = 18'h0_0000;
  localparam logic [31:0] SDR_RST_WORD      = 32'h0000_0000;
  localparam logic [3:0]  SDR_RST_RATIO     = 4'h8;

  typedef enum logic [0:0] {
    SDR_IDLE = 1'b0,
    SDR_CAL  = 1'b1
  } sdr_state_e;
endpackage : sdr_pkg

// file: core/sdr_regs.sv
/*
  Register bank for loop-two calibration divider, feedback divider,
  readback selection and write-protect lock, fed by the three-wire serial port.
  Assumes SCK, DATA, LE, CAL_DONE and EXT_RDATA are synchronous to MCLK,
  and that the registers below 29 live outside and follow EXT_WR.
*/
`timescale 1ns/1ns
// Summary of operation
// R1 - the host sets the high rate flag only when the phase detector runs above 100 MHz.
// R2 - during calibration the calibration divide value replaces the normal feedback divide.
// R3 - with an internal oscillator mode, each write to register 30 starts calibration and a sync.
// R4 - prescaler code 0 divides by 8, codes 1 and 2 by 2, codes 3 to 7 by their value.
// R5 - the feedback divide ratio equals its 18-bit code, code 0 not to be used.
// R6 - readback shifts out only while the latch-enable pin sits at the selected polarity.
// R7 - the readback address selects the register of that number, 9 and 16 to 23 give nothing.
// R8 - reading back register 12 returns the readback address in bits 20 to 16.
// R9 - the host ignores bits 6 to 31 when reading register 31.
// R10 - while locked, writes to registers 0 to 30 are ignored until the lock is written to 0.
// R11 - readback works whether or not the lock is set.
// R12 - the host sets reference and feedback dividers for equal phase detector rates.
// R13 - the host programs the reference frequency range before triggering calibration.
// R14 - a blocked write changes no stored value and starts no calibration.
module sdr_regs
  import sdr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        SCK,
  input  wire logic        DATA,
  input  wire logic        LE,
  input  wire logic        INTERNAL_VCO_MODE,
  input  wire logic        CAL_DONE,
  input  wire logic [31:0] EXT_RDATA,
  output logic             READBACK_DATA,
  output logic             HIGH_PD_RATE,
  output logic [2:0]       REF_FREQ_RANGE,
  output logic [17:0]      CAL_FEEDBACK_DIVIDE,
  output logic [17:0]      ACTIVE_FEEDBACK_DIVIDE,
  output logic [3:0]       PRESCALE_RATIO,
  output logic             CAL_BUSY,
  output logic             SYNC_PULSE,
  output logic [4:0]       READBACK_ADDR,
  output logic             EXT_WR,
  output logic [4:0]       EXT_WR_ADDR,
  output logic [31:0]      EXT_WR_DATA
);
  logic        sck_q;
  logic        le_q;
  logic [31:0] shift;
  logic [31:0] rb_shift;
  logic [2:0]  ref_range;
  logic        fast;
  logic [17:0] ncal;
  logic [2:0]  presc;
  logic [17:0] ndiv;
  logic        rb_pol;
  logic [4:0]  rb_addr;
  logic        lock;
  sdr_state_e  state;

  logic        next_sck_q, next_le_q, next_rb_data, next_fast, next_rb_pol, next_lock;
  logic [31:0] next_shift, next_rb_shift, next_ext_data;
  logic [2:0]  next_ref_range, next_presc;
  logic [17:0] next_ncal, next_ndiv, next_active;
  logic [4:0]  next_rb_addr, next_ext_addr;
  logic [3:0]  next_ratio;
  logic        next_cal_busy, next_sync, next_ext_wr;
  sdr_state_e  next_state;

  logic        sck_rise, sck_fall, latch, blocked, wr_ok, cal_start;
  logic [4:0]  wr_addr;
  logic [31:0] rb_word;

  always_comb begin
    sck_rise  = SCK & ~sck_q;
    sck_fall  = ~SCK & sck_q;
    latch     = LE & ~le_q;
    wr_addr   = shift[SDR_ADDR_LSB +: SDR_ADDR_W];
    blocked   = lock && (wr_addr != SDR_REG_RB_LOCK);                  // [R10] [R14]
    wr_ok     = latch && !blocked;
    cal_start = wr_ok && (wr_addr == SDR_REG_FB_DIV) && INTERNAL_VCO_MODE; // [R3] [R14]
  end

  // readback word selection
  always_comb begin
    rb_word = EXT_RDATA;
    unique case (rb_addr)
      SDR_REG_CAL_DIV: begin
        rb_word = SDR_RST_WORD;
        rb_word[SDR_REF_RANGE_LSB +: 3] = ref_range;
        rb_word[SDR_FAST_BIT] = fast;
        rb_word[SDR_DIV_LSB +: SDR_DIV_W] = ncal;
        rb_word[SDR_ADDR_LSB +: SDR_ADDR_W] = SDR_REG_CAL_DIV;
      end
      SDR_REG_FB_DIV: begin
        rb_word = SDR_RST_WORD;
        rb_word[SDR_PRESC_LSB +: 3] = presc;
        rb_word[SDR_DIV_LSB +: SDR_DIV_W] = ndiv;
        rb_word[SDR_ADDR_LSB +: SDR_ADDR_W] = SDR_REG_FB_DIV;
      end
      SDR_REG_RB_LOCK: begin
        rb_word = SDR_RST_WORD;
        rb_word[SDR_LOCK_BIT] = lock;                                   // [R9]
      end
      SDR_REG_STATUS12: begin
        rb_word[SDR_RB_ADDR_LSB +: SDR_ADDR_W] = rb_addr;               // [R8]
      end
      default: begin
        if (rb_addr == SDR_REG_RSV9 || (rb_addr >= SDR_RSV_LO && rb_addr <= SDR_RSV_HI)) begin
          rb_word = SDR_RST_WORD;                                       // [R7]
        end
      end
    endcase
  end

  // serial shifting, register updates and readback
  always_comb begin
    next_sck_q     = SCK;
    next_le_q      = LE;
    next_shift     = sck_rise ? {shift[30:0], DATA} : shift;
    next_ref_range = ref_range;
    next_fast      = fast;
    next_ncal      = ncal;
    next_presc     = presc;
    next_ndiv      = ndiv;
    next_rb_pol    = rb_pol;
    next_rb_addr   = rb_addr;
    next_lock      = lock;
    next_ext_wr    = 1'b0;
    next_ext_addr  = wr_addr;
    next_ext_data  = shift;
    if (wr_ok) begin
      unique case (wr_addr)
        SDR_REG_CAL_DIV: begin
          next_ref_range = shift[SDR_REF_RANGE_LSB +: 3];
          next_fast      = shift[SDR_FAST_BIT];
          next_ncal      = shift[SDR_DIV_LSB +: SDR_DIV_W];
        end
        SDR_REG_FB_DIV: begin
          next_presc = shift[SDR_PRESC_LSB +: 3];
          next_ndiv  = shift[SDR_DIV_LSB +: SDR_DIV_W];                 // [R5]
        end
        SDR_REG_RB_LOCK: begin
          next_rb_pol  = shift[SDR_RB_POL_BIT];
          next_rb_addr = shift[SDR_RB_ADDR_LSB +: SDR_ADDR_W];
          next_lock    = shift[SDR_LOCK_BIT];                           // [R10]
        end
        default: begin
          next_ext_wr = 1'b1;
        end
      endcase
    end
    // readback runs regardless of the lock
    if (latch) begin
      next_rb_shift = rb_word;                                          // [R11]
    end else if (sck_fall && (LE == rb_pol)) begin
      next_rb_shift = {rb_shift[30:0], 1'b0};                           // [R6]
    end else begin
      next_rb_shift = rb_shift;
    end
    next_rb_data = next_rb_shift[31];
    if (next_presc == 3'h0) begin
      next_ratio = SDR_PRESC_ZERO;                                      // [R4]
    end else if (next_presc < SDR_PRESC_MIN) begin
      next_ratio = SDR_PRESC_LOW;
    end else begin
      next_ratio = {1'b0, next_presc};
    end
  end

  // calibration sequencing
  always_comb begin
    next_state = state;
    next_sync  = 1'b0;
    if (cal_start) begin
      next_state = SDR_CAL;                                             // [R3]
      next_sync  = 1'b1;
    end else if (state == SDR_CAL && CAL_DONE) begin
      next_state = SDR_IDLE;
    end
    next_cal_busy = (next_state == SDR_CAL);
    next_active   = next_cal_busy ? next_ncal : next_ndiv;              // [R2]
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sck_q <= 1'b0;
      le_q <= 1'b0;
      shift <= SDR_RST_WORD;
      rb_shift <= SDR_RST_WORD;
      ref_range <= SDR_RST_3;
      fast <= 1'b0;
      ncal <= SDR_RST_DIV;
      presc <= SDR_RST_3;
      ndiv <= SDR_RST_DIV;
      rb_pol <= 1'b0;
      rb_addr <= SDR_RST_ADDR;
      lock <= 1'b0;
      state <= SDR_IDLE;
      READBACK_DATA <= 1'b0;
      HIGH_PD_RATE <= 1'b0;
      REF_FREQ_RANGE <= SDR_RST_3;
      CAL_FEEDBACK_DIVIDE <= SDR_RST_DIV;
      ACTIVE_FEEDBACK_DIVIDE <= SDR_RST_DIV;
      PRESCALE_RATIO <= SDR_RST_RATIO;
      CAL_BUSY <= 1'b0;
      SYNC_PULSE <= 1'b0;
      READBACK_ADDR <= SDR_RST_ADDR;
      EXT_WR <= 1'b0;
      EXT_WR_ADDR <= SDR_RST_ADDR;
      EXT_WR_DATA <= SDR_RST_WORD;
    end else begin
      sck_q <= next_sck_q;
      le_q <= next_le_q;
      shift <= next_shift;
      rb_shift <= next_rb_shift;
      ref_range <= next_ref_range;
      fast <= next_fast;
      ncal <= next_ncal;
      presc <= next_presc;
      ndiv <= next_ndiv;
      rb_pol <= next_rb_pol;
      rb_addr <= next_rb_addr;
      lock <= next_lock;
      state <= next_state;
      READBACK_DATA <= next_rb_data;
      HIGH_PD_RATE <= next_fast;
      REF_FREQ_RANGE <= next_ref_range;
      CAL_FEEDBACK_DIVIDE <= next_ncal;
      ACTIVE_FEEDBACK_DIVIDE <= next_active;
      PRESCALE_RATIO <= next_ratio;
      CAL_BUSY <= next_cal_busy;
      SYNC_PULSE <= next_sync;
      READBACK_ADDR <= next_rb_addr;
      EXT_WR <= next_ext_wr;
      EXT_WR_ADDR <= next_ext_addr;
      EXT_WR_DATA <= next_ext_data;
    end
  end

  // checks
  blocked_write_a: assert property (@(posedge MCLK) disable iff (RESET) // [R14]
    latch && lock && wr_addr == SDR_REG_FB_DIV |=> $stable(ndiv) && !SYNC_PULSE)
    else $error("locked write changed divider or started calibration");
  locked_ext_a: assert property (@(posedge MCLK) disable iff (RESET) // [R10]
    latch && lock && wr_addr < SDR_REG_CAL_DIV |=> !EXT_WR)
    else $error("locked write reached an outside register");
  unlocked_write_a: assert property (@(posedge MCLK) disable iff (RESET) // [R10]
    latch && !lock && wr_addr == SDR_REG_FB_DIV |=> ndiv == $past(shift[22:5]))
    else $error("unlocked write to feedback divider lost");
  cal_start_a: assert property (@(posedge MCLK) disable iff (RESET) // [R3]
    latch && !lock && wr_addr == SDR_REG_FB_DIV && INTERNAL_VCO_MODE
      |=> CAL_BUSY && SYNC_PULSE ##1 !SYNC_PULSE || $past(cal_start))
    else $error("calibration or sync missing after register 30 write");
  divide_sel_a: assert property (@(posedge MCLK) disable iff (RESET) // [R2]
    ACTIVE_FEEDBACK_DIVIDE == (CAL_BUSY ? ncal : ndiv))
    else $error("wrong feedback divide in use");
  prescale_a: assert property (@(posedge MCLK) disable iff (RESET) // [R4]
    PRESCALE_RATIO == ((presc == 3'h0) ? 4'h8 : (presc < 3'h3) ? 4'h2 : {1'b0, presc}))
    else $error("prescaler ratio decoded wrongly");
  r12_insert_a: assert property (@(posedge MCLK) disable iff (RESET) // [R8]
    latch && rb_addr == SDR_REG_STATUS12 |=> rb_shift[20:16] == $past(rb_addr))
    else $error("register 12 readback lacks readback address");
  reserved_rb_a: assert property (@(posedge MCLK) disable iff (RESET) // [R7]
    latch && (rb_addr == SDR_REG_RSV9 || rb_addr == SDR_RSV_LO) |=> rb_shift == 32'h0000_0000)
    else $error("reserved readback address returned data");
  rb_hold_a: assert property (@(posedge MCLK) disable iff (RESET) // [R6]
    !latch && LE != rb_pol |=> $stable(rb_shift))
    else $error("readback shifted at wrong latch polarity");
  locked_rb_a: assert property (@(posedge MCLK) disable iff (RESET) // [R11]
    latch && lock && rb_addr == SDR_REG_CAL_DIV |=> rb_shift[22:5] == ncal)
    else $error("readback failed while locked");

  cal_run_c: cover property (@(posedge MCLK) disable iff (RESET) cal_start ##[1:20] CAL_DONE);
  blocked_c: cover property (@(posedge MCLK) disable iff (RESET) latch && blocked);
  rb12_c: cover property (@(posedge MCLK) disable iff (RESET)
    latch && rb_addr == SDR_REG_STATUS12);
endmodule : sdr_regs

// file: verification/sdr_host_model.sv
/*
  host model for the three-wire serial port: shifts words in and readback out.
  assumes MCLK at 100 MHz and a bench that calls its tasks.
*/
`timescale 1ns/1ns
module sdr_host_model (
  input  wire logic MCLK,
  input  wire logic READBACK_DATA,
  output logic      SCK,
  output logic      DATA,
  output logic      LE
);
  initial begin
    SCK  = 1'b0;
    DATA = 1'b0;
    LE   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick
  // msb first, one cycle per clock level, latch on rising edge
  task automatic xfer(input logic [31:0] w, input logic p);
    LE = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      DATA = w[i];
      SCK  = 1'b1;
      tick(1);
      SCK  = 1'b0;
      tick(1);
    end
    LE = 1'b1;
    tick(3);
    LE = p; // held at readback level
    tick(1);
  endtask : xfer
  task automatic shift_out(output logic [31:0] r);
    tick(1);
    r[31] = READBACK_DATA;
    for (int i = 30; i >= 0; i--) begin
      SCK = 1'b1;
      tick(1);
      SCK = 1'b0;
      tick(3);
      r[i] = READBACK_DATA;
    end
  endtask : shift_out
endmodule : sdr_host_model

// file: verification/test_sdr_regs.sv
/*
  self-checking bench for the loop-two divider, readback and lock bank.
  assumes sdr_pkg and the host model; outside registers are a fixed word.
*/
`timescale 1ns/1ns
module test_sdr_regs;
  import sdr_pkg::*;
  logic        MCLK, RESET, SCK, DATA, LE, INTERNAL_VCO_MODE, CAL_DONE;
  logic        READBACK_DATA, HIGH_PD_RATE, CAL_BUSY, SYNC_PULSE, EXT_WR;
  logic [31:0] EXT_RDATA, EXT_WR_DATA, wr_data, r;
  logic [2:0]  REF_FREQ_RANGE;
  logic [17:0] CAL_FEEDBACK_DIVIDE, ACTIVE_FEEDBACK_DIVIDE;
  logic [3:0]  PRESCALE_RATIO;
  logic [4:0]  READBACK_ADDR, EXT_WR_ADDR, wr_addr;
  int          errors, check_count, n_sync, n_wr, s;
  localparam logic [31:0] W29 = {5'h00, 3'h5, 1'b1, 18'h3_ffff, 5'h1d};
  sdr_regs uut (.MCLK(MCLK), .RESET(RESET), .SCK(SCK), .DATA(DATA), .LE(LE),
    .INTERNAL_VCO_MODE(INTERNAL_VCO_MODE), .CAL_DONE(CAL_DONE), .EXT_RDATA(EXT_RDATA),
    .READBACK_DATA(READBACK_DATA), .HIGH_PD_RATE(HIGH_PD_RATE),
    .REF_FREQ_RANGE(REF_FREQ_RANGE), .CAL_FEEDBACK_DIVIDE(CAL_FEEDBACK_DIVIDE),
    .ACTIVE_FEEDBACK_DIVIDE(ACTIVE_FEEDBACK_DIVIDE), .PRESCALE_RATIO(PRESCALE_RATIO),
    .CAL_BUSY(CAL_BUSY), .SYNC_PULSE(SYNC_PULSE), .READBACK_ADDR(READBACK_ADDR),
    .EXT_WR(EXT_WR), .EXT_WR_ADDR(EXT_WR_ADDR), .EXT_WR_DATA(EXT_WR_DATA));
  sdr_host_model host (.MCLK(MCLK), .READBACK_DATA(READBACK_DATA), .SCK(SCK),
    .DATA(DATA), .LE(LE));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    if (SYNC_PULSE === 1'b1) n_sync++;
    if (EXT_WR === 1'b1) begin
      n_wr++;
      wr_addr = EXT_WR_ADDR;
      wr_data = EXT_WR_DATA;
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] rbw(input logic [4:0] a, input logic p, input logic l);
    return {10'h000, p, a, 10'h000, l, 5'h1f};
  endfunction : rbw
  task automatic rd(input logic [4:0] a, input logic p, input logic l);
    host.xfer(rbw(a, p, l), p);
    host.xfer(rbw(a, p, l), p);
    host.shift_out(r);
  endtask : rd
  task automatic t_reset();
    chk("ratio", 4'h8, PRESCALE_RATIO);
    chk("busy", 1'b0, CAL_BUSY);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_caldiv();
    host.xfer(W29, 1'b0); // rate above 100 MHz, range set first
    chk("fast", 1'b1, HIGH_PD_RATE);
    chk("range", 3'h5, REF_FREQ_RANGE);
    chk("caldiv", 18'h3_ffff, CAL_FEEDBACK_DIVIDE);
    $display("t_caldiv done");
  endtask : t_caldiv
  task automatic t_presc();
    logic [17:0] n;
    s = n_sync;
    for (int c = 0; c < 8; c++) begin
      n = c[0] ? 18'h3_ffff : 18'h0_0001;
      host.xfer({5'h00, c[2:0], 1'b0, n, 5'h1e}, 1'b0);
      chk("ratio", (c == 0) ? 8 : (c < 3) ? 2 : c, PRESCALE_RATIO);
      chk("fbdiv", n, ACTIVE_FEEDBACK_DIVIDE);
    end
    chk("nosync", s, n_sync);
    $display("t_presc done");
  endtask : t_presc
  task automatic t_cal();
    INTERNAL_VCO_MODE = 1'b1;
    s = n_sync;
    host.xfer({5'h00, 3'h3, 1'b0, 18'h0_0019, 5'h1e}, 1'b0); // p*n for equal rates
    chk("busy", 1'b1, CAL_BUSY);
    chk("sync", s + 1, n_sync);
    chk("calsub", 18'h3_ffff, ACTIVE_FEEDBACK_DIVIDE);
    CAL_DONE = 1'b1;
    host.tick(3);
    CAL_DONE = 1'b0;
    host.tick(2);
    chk("idle", 1'b0, CAL_BUSY);
    chk("fbdiv", 18'h0_0019, ACTIVE_FEEDBACK_DIVIDE);
    $display("t_cal done");
  endtask : t_cal
  task automatic t_ext();
    s = n_wr;
    host.xfer(32'ha5a5_a5a5, 1'b0);
    chk("wrcnt", s + 1, n_wr);
    chk("wraddr", 5'h05, wr_addr);
    chk("wrdata", 32'ha5a5_a5a5, wr_data);
    $display("t_ext done");
  endtask : t_ext
  task automatic t_rb();
    EXT_RDATA = 32'hffff_ffff;
    rd(5'h1d, 1'b0, 1'b0);
    chk("rb29", W29, r);
    chk("rbaddr", 5'h1d, READBACK_ADDR);
    rd(5'h0c, 1'b1, 1'b0);
    chk("rb12", 32'hffec_ffff, r);
    rd(5'h09, 1'b0, 1'b0);
    chk("rb9", 32'h0, r);
    rd(5'h17, 1'b0, 1'b0);
    chk("rb23", 32'h0, r);
    rd(5'h05, 1'b0, 1'b0);
    chk("rb5", 32'hffff_ffff, r);
    $display("t_rb done");
  endtask : t_rb
  task automatic t_lock();
    host.xfer(rbw(5'h1d, 1'b0, 1'b1), 1'b0);
    s = n_wr;
    host.xfer(32'h0000_001d, 1'b0);
    host.xfer({5'h00, 3'h6, 1'b0, 18'h0_0002, 5'h1e}, 1'b0);
    host.xfer(32'ha5a5_a5a5, 1'b0);
    chk("lockfast", 1'b1, HIGH_PD_RATE);
    chk("lockratio", 4'h3, PRESCALE_RATIO);
    chk("locksync", 1'b0, CAL_BUSY);
    chk("lockwr", s, n_wr);
    rd(5'h1d, 1'b0, 1'b1);
    chk("rblock", W29, r);
    rd(5'h1f, 1'b0, 1'b1);
    chk("lockbit", 1'b1, r[5]); // only bit 5 is meaningful
    host.xfer(rbw(5'h1d, 1'b0, 1'b0), 1'b0);
    host.xfer(32'h0000_001d, 1'b0);
    chk("unlock", 1'b0, HIGH_PD_RATE);
    $display("t_lock done");
  endtask : t_lock
  initial begin
    RESET = 1'b1;
    INTERNAL_VCO_MODE = 1'b0;
    CAL_DONE = 1'b0;
    EXT_RDATA = 32'h0;
    repeat (3) @(posedge MCLK);
    #1;
    RESET = 1'b0;
    host.tick(1);
    t_reset();
    t_caldiv();
    t_presc();
    t_cal();
    t_ext();
    t_rb();
    t_lock();
    close_out();
  end
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule : test_sdr_regs
